// File: bench/ccr_bank_tb.sv
// ccr_bank_tb: self-checking bench for the charger control register bank.
// assumes shortened watchdog, ship delay and long wake counts.
`timescale 1ns/1ps
module ccr_bank_tb;
  logic       clock = 1'b0;
  logic       nrst = 1'b0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       register_reset = 1'b0;
  logic       vbus_present = 1'b0;
  logic       wake_pin = 1'b1;
  logic       clk_en = 1'b1;
  logic       drv_one = 1'b1;
  logic       drv_two = 1'b1;
  logic [7:0] reg_rdata;
  logic       detect_done, detect_start, hv_hs, hv_12, hv_9, wd_exp, wake_event;
  logic       g1, g2, rb, rll, fll, pre, rmf, fmf, hit;
  logic [1:0] ship_req, ovp_sel;
  int         mismatches = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         det_cnt = 0;
  int         wake_cnt = 0;
  int         n;

  always #10 clock = ~clock;

  ccr_bank #(.WD_UNIT_CYC(10), .SHIP_DLY_CYC(20), .WAKE_LONG_CYC(8)) i_ccr_bank (
    .clock(clock), .nrst(nrst), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(hit), .register_reset(register_reset),
    .vbus_present(vbus_present), .detect_done(detect_done), .detect_start(detect_start),
    .hv_handshake_allow(hv_hs), .hv_twelve_allow(hv_12), .hv_nine_allow(hv_9),
    .input_overvoltage_threshold_select(ovp_sel), .wake_pin(wake_pin),
    .ship_mode_request(ship_req), .wake_event(wake_event),
    .input_gate_driver_one_on(drv_one), .input_gate_driver_two_on(drv_two),
    .gate_one_drive(g1), .gate_two_drive(g2), .reverse_boost_enable(rb),
    .reverse_light_load_allow(rll), .forward_light_load_allow(fll),
    .precharge_linear_allow(pre), .reverse_min_freq_allow(rmf),
    .forward_min_freq_allow(fmf), .watchdog_expired(wd_exp));

  ccr_detector_model i_ccr_detector_model (
    .clock(clock), .nrst(nrst), .detect_start(detect_start), .detect_done(detect_done));

  // ****************************************
  // pulse counters and hang guard
  // ****************************************
  always @(posedge clock) begin
    cyc++;
    if (detect_start === 1'b1) det_cnt++;
    if (wake_event === 1'b1) wake_cnt++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end

  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // extra idle cycle so self-clearing bits settle before the next access
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
    @(negedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask : rd

  task automatic idle(input int c);
    repeat (c) @(negedge clock);
  endtask : idle

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  function automatic logic [7:0] conv();
    return {2'h0, rb, rll, fll, pre, rmf, fmf};
  endfunction : conv

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    idle(5);
    nrst = 1'b1;
    rd(8'h10, 8'h85);
    chk({7'h0, hit}, 8'h01);
    rd(8'h11, 8'h40);
    rd(8'h12, 8'h00);
    rd(8'h13, 8'h00);
    chk({7'h0, hit}, 8'h00);
    chk({6'h0, g1, g2}, 8'h03);
    chk(conv(), 8'h1f);
    chk({6'h0, ovp_sel}, 8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h37);
    chk({6'h0, ovp_sel}, 8'h03);
    wr(8'h10, 8'h20);
    wr(8'h11, 8'h38);
    chk({5'h0, hv_hs, hv_12, hv_9}, 8'h07);
    wr(8'h11, 8'h30);
    chk({5'h0, hv_hs, hv_12, hv_9}, 8'h00);
    wr(8'h11, 8'h18);
    chk({5'h0, hv_hs, hv_12, hv_9}, 8'h05);
    wr(8'h11, 8'h38);
    wr(8'h12, 8'hff);
    chk({6'h0, g1, g2}, 8'h00);
    chk(conv(), 8'h20);
    wr(8'h10, 8'h21);
    for (n = 0; n < 200 && wd_exp !== 1'b1; n++) @(negedge clock);
    chk({7'h0, wd_exp}, 8'h01);
    rd(8'h10, 8'h21);
    rd(8'h11, 8'h78);
    rd(8'h12, 8'h99);
    chk(conv(), 8'h16);
    wr(8'h10, 8'h20);
    det_cnt = 0;
    wr(8'h11, 8'h80);
    rd(8'h11, 8'h80);
    idle(20);
    rd(8'h11, 8'h00);
    vbus_present = 1'b1;
    idle(20);
    chk(8'(det_cnt), 8'h01);
    vbus_present = 1'b0;
    wr(8'h11, 8'h40);
    idle(10);
    vbus_present = 1'b1;
    idle(20);
    chk(8'(det_cnt), 8'h02);
    for (int c = 1; c < 4; c++) begin
      wr(8'h11, {5'h0, 2'(c), 1'b1});
      chk({6'h0, ship_req}, 8'(c));
    end
    wr(8'h11, 8'h00);
    wr(8'h11, 8'h04);
    chk({7'h0, ship_req === 2'h2}, 8'h00);
    for (n = 0; n < 60 && ship_req !== 2'h2; n++) @(negedge clock);
    chk({7'h0, n > 14 && n < 60}, 8'h01);
    wr(8'h12, 8'h00);
    wake_cnt = 0;
    wake_pin = 1'b0;
    idle(3);
    wake_pin = 1'b1;
    idle(12);
    chk(8'(wake_cnt), 8'h00);
    wake_pin = 1'b0;
    idle(20);
    wake_pin = 1'b1;
    idle(5);
    chk(8'(wake_cnt), 8'h01);
    // a frozen bank must ignore a write
    clk_en = 1'b0;
    wr(8'h12, 8'h55);
    clk_en = 1'b1;
    rd(8'h12, 8'h00);
    wr(8'h10, 8'h3d);
    register_reset = 1'b1;
    idle(1);
    register_reset = 1'b0;
    rd(8'h10, 8'h85);
    chk({6'h0, ovp_sel}, 8'h00);
    rd(8'h11, 8'h40);
    rd(8'h12, 8'h00);
    close_out();
  end
endmodule : ccr_bank_tb

// File: bench/ccr_detector_model.sv
// ccr_detector_model: stand-in adapter detector that answers detection starts.
// assumes detect_start is a one-cycle pulse on the bank's clock.
`timescale 1ns/1ps
module ccr_detector_model #(
  parameter int DONE_DLY = 5
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // detection handshake
  input  wire logic detect_start,
  output logic      detect_done
);
  int cnt;

  // a slow detector, so the forced bit must stay set for several cycles
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      detect_done <= 1'b0;
    end else begin
      detect_done <= (cnt == 1);
      if (detect_start) begin
        cnt <= DONE_DLY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : ccr_detector_model

// File: src/ccr_bank.sv
// ccr_bank: three charger control registers with their side effects.
// assumes an i2c target front end on the same clock delivers byte writes
// and reads as one-cycle strobes with an 8-bit register address.
//
// What this block does
// - kick restarts watchdog, then self-clears
// - host must kick within selected period
// - forced detection starts, clears when done
// - auto detection runs on plug-in when enabled
// - handshake only while its enable is set
// - twelve volt request needs its enable
// - nine volt request needs its enable
// - nonzero ship action enters that mode
// - ship action waits 10 s unless skipped
// - gates-off bit forces both gate drivers off
// - wake needs pin low 1 s or 15 ms
// - reverse light-load allowed unless inhibited
// - forward light-load allowed unless inhibited
// - precharge linear mode on unless inhibited
// - reverse min-frequency on unless inhibited
// - forward min-frequency on unless inhibited
`timescale 1ns/1ps
module ccr_bank import ccr_pkg::*; #(
  parameter longint WD_UNIT_CYC   = CCR_WD_UNIT_CYC,
  parameter longint SHIP_DLY_CYC  = CCR_SHIP_DLY_CYC,
  parameter longint WAKE_LONG_CYC = CCR_WAKE_LONG_CYC
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  // register access from the i2c front end
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_hit,
  input  wire logic       register_reset,
  // adapter detection
  input  wire logic       vbus_present,
  input  wire logic       detect_done,
  output logic            detect_start,
  output logic            hv_handshake_allow,
  output logic            hv_twelve_allow,
  output logic            hv_nine_allow,
  output logic      [1:0] input_overvoltage_threshold_select,
  // ship switch and wake
  input  wire logic       wake_pin,
  output logic      [1:0] ship_mode_request,
  output logic            wake_event,
  // gate drivers and converter modes
  input  wire logic       input_gate_driver_one_on,
  input  wire logic       input_gate_driver_two_on,
  output logic            gate_one_drive,
  output logic            gate_two_drive,
  output logic            reverse_boost_enable,
  output logic            reverse_light_load_allow,
  output logic            forward_light_load_allow,
  output logic            precharge_linear_allow,
  output logic            reverse_min_freq_allow,
  output logic            forward_min_freq_allow,
  output logic            watchdog_expired
);

  // ****************************************
  // registers and decode
  // ****************************************
  logic [7:0] wdog_ovp_reg, wdog_ovp_next;
  logic [7:0] det_ship_reg, det_ship_next;
  logic [7:0] conv_reg, conv_next;
  logic       wr_wdog, wr_det, wr_conv;
  logic       wd_expired;
  logic       kick;
  logic       vbus_meta_reg, vbus_sync_reg, vbus_last_reg;
  logic       wake_meta_reg, wake_sync_reg;
  logic       plug_in;
  logic       start_force, start_auto;
  logic       ship_busy, ship_done;
  logic       ship_start, ship_cancel;
  logic [1:0] ship_pend_reg;
  logic [1:0] ship_req_reg;
  logic       wake_busy;
  logic [31:0] wake_cnt_reg;
  logic [31:0] wake_need;

  assign wr_wdog = reg_wr && (reg_addr == CCR_WDOG_OVP_OFFSET);
  assign wr_det  = reg_wr && (reg_addr == CCR_DET_SHIP_OFFSET);
  assign wr_conv = reg_wr && (reg_addr == CCR_CONV_OFFSET);
  assign reg_hit = (reg_addr == CCR_WDOG_OVP_OFFSET) || (reg_addr == CCR_DET_SHIP_OFFSET)
                   || (reg_addr == CCR_CONV_OFFSET);

  // restore masked bits to their default on expiry
  function automatic logic [7:0] wd_restore(input logic [7:0] cur, input logic [7:0] dflt,
                                            input logic [7:0] mask);
    wd_restore = (cur & ~mask) | (dflt & mask);
  endfunction : wd_restore

  // ****************************************
  // input synchronisers
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      vbus_meta_reg <= 1'b0;
      vbus_sync_reg <= 1'b0;
      vbus_last_reg <= 1'b0;
      wake_meta_reg <= 1'b1;
      wake_sync_reg <= 1'b1;
    end else if (clk_en) begin
      vbus_meta_reg <= vbus_present;
      vbus_sync_reg <= vbus_meta_reg;
      vbus_last_reg <= vbus_sync_reg;
      wake_meta_reg <= wake_pin;
      wake_sync_reg <= wake_meta_reg;
    end
  end

  assign plug_in = vbus_sync_reg && !vbus_last_reg;

  // ****************************************
  // next-state of the three registers
  // ****************************************
  // kick is consumed by the watchdog in the cycle after it lands
  assign kick        = wdog_ovp_reg[CCR_WD_KICK_BIT];
  // start from the write, not the level: the bit stays set until done
  assign start_force = wr_det && reg_wdata[CCR_FORCE_DET_BIT] && !register_reset;
  assign start_auto  = plug_in && det_ship_reg[CCR_AUTO_DET_BIT];

  always_comb begin
    wdog_ovp_next = wdog_ovp_reg;
    det_ship_next = det_ship_reg;
    conv_next     = conv_reg;
    // self-clear first so a new write in the same cycle wins
    wdog_ovp_next[CCR_WD_KICK_BIT] = 1'b0;
    if (detect_done) begin
      det_ship_next[CCR_FORCE_DET_BIT] = 1'b0;
    end
    if (wd_expired) begin
      wdog_ovp_next = wd_restore(wdog_ovp_next, CCR_WDOG_OVP_RESET,
                                 CCR_WDOG_OVP_WD_MASK);
      det_ship_next = wd_restore(det_ship_next, CCR_DET_SHIP_RESET, CCR_DET_SHIP_WD_MASK);
      conv_next     = wd_restore(conv_next, CCR_CONV_RESET, CCR_CONV_WD_MASK);
    end
    if (wr_wdog) begin
      wdog_ovp_next = reg_wdata & CCR_WDOG_OVP_WR_MASK;
    end
    if (wr_det) begin
      det_ship_next = reg_wdata;
    end
    if (wr_conv) begin
      conv_next = reg_wdata;
    end
  end

  // ovp select and period are only restored here, never by expiry
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wdog_ovp_reg <= CCR_WDOG_OVP_RESET;
      det_ship_reg <= CCR_DET_SHIP_RESET;
      conv_reg     <= CCR_CONV_RESET;
    end else if (clk_en) begin
      if (register_reset) begin
        wdog_ovp_reg <= CCR_WDOG_OVP_RESET;
        det_ship_reg <= CCR_DET_SHIP_RESET;
        conv_reg     <= CCR_CONV_RESET;
      end else begin
        wdog_ovp_reg <= wdog_ovp_next;
        det_ship_reg <= det_ship_next;
        conv_reg     <= conv_next;
      end
    end
  end

  // ****************************************
  // watchdog
  // ****************************************
  ccr_watchdog #(
    .UNIT_CYC (WD_UNIT_CYC)
  ) u_wdog (
    .clock      (clock),
    .nrst       (nrst),
    .clk_en     (clk_en),
    .period_sel (wdog_ovp_reg[CCR_WD_PERIOD_LSB +: 3]),
    .kick       (kick),
    .expired    (wd_expired)
  );

  // ****************************************
  // ship switch action with optional delay
  // ****************************************
  assign ship_start  = wr_det && (reg_wdata[CCR_SHIP_ACT_LSB +: 2] != CCR_SHIP_IDLE)
                       && !reg_wdata[CCR_SHIP_DLY_BIT];
  assign ship_cancel = wr_det && (reg_wdata[CCR_SHIP_ACT_LSB +: 2] == CCR_SHIP_IDLE);

  // an immediate action drops a delayed one still counting
  ccr_delay_timer u_ship_dly (
    .clock       (clock),
    .nrst        (nrst),
    .clk_en      (clk_en),
    .start       (ship_start),
    .cancel      (ship_cancel || register_reset || (wr_det && reg_wdata[CCR_SHIP_DLY_BIT])),
    .load_cycles (32'(SHIP_DLY_CYC)),
    .busy        (ship_busy),
    .done        (ship_done)
  );

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ship_pend_reg <= CCR_SHIP_IDLE;
      ship_req_reg  <= CCR_SHIP_IDLE;
    end else if (clk_en) begin
      if (register_reset || ship_cancel) begin
        ship_req_reg <= CCR_SHIP_IDLE;
      end else if (wr_det && reg_wdata[CCR_SHIP_DLY_BIT]) begin
        ship_req_reg <= reg_wdata[CCR_SHIP_ACT_LSB +: 2];
      end else if (ship_done) begin
        ship_req_reg <= ship_pend_reg;
      end
      if (ship_start) begin
        ship_pend_reg <= reg_wdata[CCR_SHIP_ACT_LSB +: 2];
      end
    end
  end

  // ****************************************
  // wake from ship mode: pin held low
  // ****************************************
  assign wake_need = conv_reg[CCR_WAKE_DLY_BIT] ? 32'(CCR_WAKE_SHORT_CYC) : 32'(WAKE_LONG_CYC);
  assign wake_busy = (ship_req_reg == CCR_SHIP_SHIP) && !wake_sync_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wake_cnt_reg <= '0;
      wake_event   <= 1'b0;
    end else if (clk_en) begin
      wake_event <= 1'b0;
      // counter parks at the limit: one wake per press, however long held
      if (!wake_busy) begin
        wake_cnt_reg <= '0;
      end else if (wake_cnt_reg + 32'h1 == wake_need) begin
        wake_cnt_reg <= wake_need;
        wake_event   <= 1'b1;
      end else if (wake_cnt_reg < wake_need) begin
        wake_cnt_reg <= wake_cnt_reg + 32'h1;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata    <= 8'h00;
      detect_start <= 1'b0;
    end else if (clk_en) begin
      detect_start <= start_auto || start_force;
      if (reg_rd) begin
        case (reg_addr)
          CCR_WDOG_OVP_OFFSET: reg_rdata <= wdog_ovp_reg;
          CCR_DET_SHIP_OFFSET: reg_rdata <= det_ship_reg;
          CCR_CONV_OFFSET:     reg_rdata <= conv_reg;
          default:             reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  assign input_overvoltage_threshold_select = wdog_ovp_reg[CCR_OVP_LSB +: 2];
  assign hv_handshake_allow = det_ship_reg[CCR_HVH_EN_BIT];
  assign hv_twelve_allow    = det_ship_reg[CCR_HVH_EN_BIT]
                              && det_ship_reg[CCR_TWELVE_V_BIT];
  assign hv_nine_allow      = det_ship_reg[CCR_HVH_EN_BIT]
                              && det_ship_reg[CCR_NINE_V_BIT];
  assign ship_mode_request  = ship_req_reg;
  assign gate_one_drive     = input_gate_driver_one_on
                              && !conv_reg[CCR_GATES_OFF_BIT];
  assign gate_two_drive     = input_gate_driver_two_on
                              && !conv_reg[CCR_GATES_OFF_BIT];
  assign reverse_boost_enable     = conv_reg[CCR_BOOST_EN_BIT];
  assign reverse_light_load_allow = !conv_reg[CCR_REV_LL_BIT];
  assign forward_light_load_allow = !conv_reg[CCR_FWD_LL_BIT];
  assign precharge_linear_allow   = !conv_reg[CCR_PRE_LIN_BIT];
  assign reverse_min_freq_allow   = !conv_reg[CCR_REV_MF_BIT];
  assign forward_min_freq_allow   = !conv_reg[CCR_FWD_MF_BIT];
  assign watchdog_expired = wd_expired;

  // ****************************************
  // checks
  // ****************************************
  chk_kick_clears: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && wr_wdog && reg_wdata[CCR_WD_KICK_BIT] && !register_reset
    |=> kick ##1 (!kick || !clk_en || $past(wr_wdog)))
    else $error("kick bit did not self-clear");
  chk_expiry_keeps_ovp: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && wd_expired && !reg_wr && !register_reset
    |=> $stable(wdog_ovp_reg[CCR_OVP_LSB +: 2]) && !det_ship_reg[CCR_FORCE_DET_BIT])
    else $error("expiry disturbed fields it must keep");
  chk_force_clears: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && detect_done && !wr_det && !register_reset |=> !det_ship_reg[CCR_FORCE_DET_BIT])
    else $error("forced detection bit not cleared");
  chk_auto_detect: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && plug_in && !start_force
    |=> detect_start == $past(det_ship_reg[CCR_AUTO_DET_BIT]))
    else $error("auto detection mismatch");
  chk_handshake_gate: assert property (@(posedge clock) disable iff (!nrst)
    (hv_twelve_allow || hv_nine_allow) |-> hv_handshake_allow)
    else $error("voltage request without handshake enable");
  chk_gates_off: assert property (@(posedge clock) disable iff (!nrst)
    conv_reg[CCR_GATES_OFF_BIT] |-> !gate_one_drive && !gate_two_drive)
    else $error("gate driver on while forced off");
  chk_ship_immediate: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && wr_det && reg_wdata[CCR_SHIP_DLY_BIT] && !register_reset
    |=> ship_mode_request == $past(reg_wdata[CCR_SHIP_ACT_LSB +: 2]))
    else $error("immediate ship action not taken");
  chk_ship_delayed: assert property (@(posedge clock) disable iff (!nrst)
    ship_start && clk_en && !register_reset
    |=> ship_busy && ship_mode_request == $past(ship_req_reg))
    else $error("delayed ship action acted early");

endmodule : ccr_bank

// File: src/ccr_delay_timer.sv
// ccr_delay_timer: one-shot counter, done pulses after load_cycles.
// assumes start is a one-cycle request on the same clock.
`timescale 1ns/1ps
module ccr_delay_timer (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  // control
  input  wire logic        start,
  input  wire logic        cancel,
  input  wire logic [31:0] load_cycles,
  // status
  output logic             busy,
  output logic             done
);

  logic [31:0] count_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (cancel) begin
        busy <= 1'b0;
      end else if (start) begin
        busy      <= 1'b1;
        count_reg <= load_cycles;
      end else if (busy) begin
        if (count_reg <= 32'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count_reg <= count_reg - 32'h1;
        end
      end
    end
  end

endmodule : ccr_delay_timer

// File: src/ccr_pkg.sv
// ccr_pkg: offsets, field positions, reset values and timing for the
// charger control register bank.
// assumes a 50 MHz core clock; used by ccr_bank and ccr_watchdog of the bank.
package ccr_pkg;

  // ****************************************
  // register offsets and reset values
  // ****************************************
  localparam logic [7:0] CCR_WDOG_OVP_OFFSET = 8'h10;
  localparam logic [7:0] CCR_DET_SHIP_OFFSET = 8'h11;
  localparam logic [7:0] CCR_CONV_OFFSET     = 8'h12;
  localparam logic [7:0] CCR_WDOG_OVP_RESET  = 8'h85;
  localparam logic [7:0] CCR_DET_SHIP_RESET  = 8'h40;
  localparam logic [7:0] CCR_CONV_RESET      = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CCR_WD_PERIOD_LSB = 0;
  localparam int CCR_WD_KICK_BIT   = 3;
  localparam int CCR_OVP_LSB       = 4;
  localparam int CCR_SHIP_DLY_BIT  = 0;
  localparam int CCR_SHIP_ACT_LSB  = 1;
  localparam int CCR_HVH_EN_BIT    = 3;
  localparam int CCR_NINE_V_BIT    = 4;
  localparam int CCR_TWELVE_V_BIT  = 5;
  localparam int CCR_AUTO_DET_BIT  = 6;
  localparam int CCR_FORCE_DET_BIT = 7;
  localparam int CCR_GATES_OFF_BIT = 7;
  localparam int CCR_FWD_MF_BIT    = 0;
  localparam int CCR_REV_MF_BIT    = 1;
  localparam int CCR_PRE_LIN_BIT   = 2;
  localparam int CCR_WAKE_DLY_BIT  = 3;
  localparam int CCR_FWD_LL_BIT    = 4;
  localparam int CCR_REV_LL_BIT    = 5;
  localparam int CCR_BOOST_EN_BIT  = 6;

  // bits returned to default on watchdog expiry, per register
  localparam logic [7:0] CCR_WDOG_OVP_WD_MASK = 8'h08;
  localparam logic [7:0] CCR_DET_SHIP_WD_MASK = 8'hc0;
  localparam logic [7:0] CCR_CONV_WD_MASK     = 8'h66;
  // writable bits of the first register; 7:6 read zero once written
  localparam logic [7:0] CCR_WDOG_OVP_WR_MASK = 8'h3f;

  // ****************************************
  // timing
  // ****************************************
  localparam longint CCR_CLK_HZ       = 64'd50_000_000;
  localparam longint CCR_WD_UNIT_MS   = 64'd500;
  localparam longint CCR_SHIP_DLY_MS  = 64'd10_000;
  localparam longint CCR_WAKE_LONG_MS = 64'd1_000;
  localparam longint CCR_WAKE_SHORT_MS = 64'd15;
  localparam longint CCR_WD_UNIT_CYC  = CCR_CLK_HZ * CCR_WD_UNIT_MS / 64'd1000;
  localparam longint CCR_SHIP_DLY_CYC = CCR_CLK_HZ * CCR_SHIP_DLY_MS / 64'd1000;
  localparam longint CCR_WAKE_LONG_CYC = CCR_CLK_HZ * CCR_WAKE_LONG_MS / 64'd1000;
  localparam longint CCR_WAKE_SHORT_CYC = CCR_CLK_HZ * CCR_WAKE_SHORT_MS / 64'd1000;

  typedef enum logic [1:0] {
    CCR_SHIP_IDLE,
    CCR_SHIP_SHUTDOWN,
    CCR_SHIP_SHIP,
    CCR_SHIP_SYS_RESET
  } ccr_ship_type;

  // watchdog period in 0.5 s units; 0 means disabled
  function automatic logic [8:0] ccr_wd_units(input logic [2:0] sel);
    case (sel)
      3'h1: ccr_wd_units = 9'h001;
      3'h2: ccr_wd_units = 9'h002;
      3'h3: ccr_wd_units = 9'h004;
      3'h4: ccr_wd_units = 9'h028;
      3'h5: ccr_wd_units = 9'h050;
      3'h6: ccr_wd_units = 9'h0a0;
      3'h7: ccr_wd_units = 9'h140;
      default: ccr_wd_units = 9'h000;
    endcase
  endfunction : ccr_wd_units

endpackage : ccr_pkg

// File: src/ccr_watchdog.sv
// ccr_watchdog: host-link watchdog counting in 0.5 s units.
// assumes kick and period come from the register bank on the same clock.
`timescale 1ns/1ps
module ccr_watchdog import ccr_pkg::*; #(
  parameter longint UNIT_CYC = CCR_WD_UNIT_CYC
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  // control
  input  wire logic [2:0] period_sel,
  input  wire logic       kick,
  // status
  output logic            expired
);

  logic [31:0] tick_reg;
  logic [8:0]  unit_reg;
  logic [8:0]  limit;
  logic        unit_done;
  logic        enabled;

  assign limit     = ccr_wd_units(period_sel);
  assign enabled   = (limit != 9'h000);
  assign unit_done = (tick_reg == 32'(UNIT_CYC - 1));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick_reg <= '0;
      unit_reg <= '0;
      expired  <= 1'b0;
    end else if (clk_en) begin
      expired <= 1'b0;
      if (kick || !enabled) begin
        tick_reg <= '0;
        unit_reg <= '0;
      end else if (unit_done) begin
        tick_reg <= '0;
        if (unit_reg + 9'h001 >= limit) begin
          unit_reg <= '0;
          expired  <= 1'b1;
        end else begin
          unit_reg <= unit_reg + 9'h001;
        end
      end else begin
        tick_reg <= tick_reg + 32'h1;
      end
    end
  end

  chk_kick_restarts: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && kick |=> !expired && tick_reg == '0)
    else $error("watchdog not restarted by kick");

endmodule : ccr_watchdog
